// ---- hw/pga_params.svh ----
`ifndef PGA_PARAMS_SVH
`define PGA_PARAMS_SVH

// Host I/O addresses (low address byte).
`define PGA_IE_ADDR      8'h80
`define PGA_PB_ADDR      8'h81
`define PGA_PC_ADDR      8'h82
`define PGA_DRST_ADDR    8'h83
`define PGA_PA_ADDR      8'h83

// Disk drive unit occupies one block of sixteen I/O addresses.
`define PGA_DISK_BASE    8'h60
`define PGA_DISK_MASK    8'hf0

// Program ROM occupies the upper 32KB of memory space.
`define PGA_ROM_BASE     16'h8000
`define PGA_ROM_MASK     16'h8000

// Reset values.
`define PGA_LATCH_RST    8'h00
`define PGA_DRST_RST     1'b1

// Field layout of the interrupt-enable latch.
`define PGA_EN_MSB       6
`define PGA_EN_LSB       0

// Latch storage indices.
`define PGA_IDX_IE       2'd0
`define PGA_IDX_PB       2'd1
`define PGA_IDX_PC       2'd2

// Synchroniser depth for pin inputs.
`define PGA_SYNC_STAGES  2

`endif

// ---- hw/pga_pkg.sv ----
`include "pga_params.svh"

package pga_pkg;

  typedef enum logic [2:0]
  {
    PGA_TGT_NONE = 3'h0,
    PGA_TGT_IE   = 3'h1,
    PGA_TGT_PB   = 3'h3,
    PGA_TGT_PC   = 3'h2,
    PGA_TGT_DRST = 3'h6,
    PGA_TGT_PA   = 3'h7
  } pga_target_t;

  // Maps an I/O address and direction to the addressed item.
  function automatic pga_target_t pga_io_target(input logic [7:0] addr,
                                                input logic       is_wr);
    pga_target_t t;
    t = PGA_TGT_NONE;
    if (addr == `PGA_IE_ADDR)
      t = PGA_TGT_IE;
    else if (addr == `PGA_PB_ADDR)
      t = PGA_TGT_PB;
    else if (addr == `PGA_PC_ADDR)
      t = PGA_TGT_PC;
    else if (is_wr && (addr == `PGA_DRST_ADDR))
      t = PGA_TGT_DRST;
    else if (!is_wr && (addr == `PGA_PA_ADDR))
      t = PGA_TGT_PA;
    return t;
  endfunction : pga_io_target

endpackage : pga_pkg

// ---- hw/pga_sync.sv ----
`timescale 1ns/1ps
`include "pga_params.svh"

module pga_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg [0:`PGA_SYNC_STAGES-1];

  // Reset value is a tie-off constant from the parent, never a live pin.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `PGA_SYNC_STAGES; i++)
        stage_reg[i] <= rst_val_in;
    end
    else if (ce_in)
    begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < `PGA_SYNC_STAGES; i++)
        stage_reg[i] <= stage_reg[i-1];
    end
  end

  assign sync_out = stage_reg[`PGA_SYNC_STAGES-1];

endmodule : pga_sync

// ---- hw/pga_decoder.sv ----
`timescale 1ns/1ps
`include "pga_params.svh"

module pga_decoder (
  input  wire logic                 [15:0] addr_in,
  input  wire logic                        io_cycle_in,
  input  wire logic                        mem_cycle_in,
  input  wire logic                        wr_in,
  output logic                             rom_sel_out,
  output logic                             disk_sel_out,
  output pga_pkg::pga_target_t             wr_target_out,
  output pga_pkg::pga_target_t             rd_target_out
);
  import pga_pkg::*;

  wire logic [7:0] io_addr = addr_in[7:0];
  wire logic       rom_hit = (addr_in & `PGA_ROM_MASK) == `PGA_ROM_BASE;
  wire logic       disk_hit = (io_addr & `PGA_DISK_MASK) == `PGA_DISK_BASE;

  assign rom_sel_out   = mem_cycle_in && rom_hit;
  assign disk_sel_out  = io_cycle_in && disk_hit;
  assign wr_target_out = (io_cycle_in && wr_in) ?
                         pga_io_target(io_addr, 1'b1) : PGA_TGT_NONE;
  assign rd_target_out = (io_cycle_in && !wr_in) ?
                         pga_io_target(io_addr, 1'b0) : PGA_TGT_NONE;

endmodule : pga_decoder

// ---- hw/pga_io_gate.sv ----

`timescale 1ns/1ps
`include "pga_params.svh"

module pga_io_gate (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic [15:0] host_addr_in,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe_out,
  input  wire logic        host_iorq_n_in,
  input  wire logic        host_mreq_n_in,
  input  wire logic        host_m1_n_in,
  input  wire logic        host_rd_n_in,
  input  wire logic        host_wr_n_in,
  output logic             host_irq_out,
  input  wire logic [7:0]  interrupt_input_port_in,
  input  wire logic        external_reset_in,
  output logic      [7:0]  port_b_pins_n_out,
  output logic      [7:0]  port_c_pins_n_out,
  output logic             rom_select_n_out,
  output logic             disk_select_n_out,
  output logic             disk_reset_n_out
);
  import pga_pkg::*;

  localparam int SYNC_W = 16 + 8 + 8 + 5 + 1;

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic [SYNC_W-1:0] pins_rst_val;

  logic [15:0] addr_s;
  logic [7:0]  data_s;
  logic [7:0]  pa_s;
  logic        iorq_n_s;
  logic        mreq_n_s;
  logic        m1_n_s;
  logic        rd_n_s;
  logic        wr_n_s;
  logic        ext_rst_s;

  // All host and port pins arrive from outside the clock domain.
  assign pins_async = {host_addr_in, host_data_in, interrupt_input_port_in,
                       host_iorq_n_in, host_mreq_n_in, host_m1_n_in,
                       host_rd_n_in, host_wr_n_in, external_reset_in};

  // Strobes idle high, everything else idles low.
  assign pins_rst_val = {16'h0000, 8'h00, 8'h00, 5'h1f, 1'b0};

  pga_sync #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .async_in   (pins_async),
    .rst_val_in (pins_rst_val),
    .sync_out   (pins_sync)
  );

  assign {addr_s, data_s, pa_s, iorq_n_s, mreq_n_s, m1_n_s,
          rd_n_s, wr_n_s, ext_rst_s} = pins_sync;

  // An I/O cycle with M1 low is an interrupt acknowledge, not a port access.
  wire logic io_cycle  = !iorq_n_s && m1_n_s;
  wire logic mem_cycle = !mreq_n_s;
  wire logic wr_act    = !wr_n_s;
  wire logic rd_act    = !rd_n_s;

  logic        rom_sel;
  logic        disk_sel;
  pga_target_t wr_target;
  pga_target_t rd_target;

  pga_decoder u_decoder (
    .addr_in       (addr_s),
    .io_cycle_in   (io_cycle),
    .mem_cycle_in  (mem_cycle && (wr_act || rd_act)),
    .wr_in         (wr_act),
    .rom_sel_out   (rom_sel),
    .disk_sel_out  (disk_sel),
    .wr_target_out (wr_target),
    .rd_target_out (rd_target)
  );

  // Write strobe edge: the latch loads once per host write, on the first
  // cycle the synchronised strobe is seen, so a long strobe is harmless.
  logic wr_seen_reg;
  wire logic wr_strobe = io_cycle && wr_act;
  wire logic wr_pulse  = wr_strobe && !wr_seen_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      wr_seen_reg <= 1'b0;
    else if (ce_in)
      wr_seen_reg <= wr_strobe;
  end

  // Reset sources: the block reset and the external reset pin.
  wire logic latch_clear = ext_rst_s;

  // Latch storage, addressed by index.
  logic [7:0] latch_reg [0:2];
  logic [1:0] wr_index;
  logic       wr_latch;

  assign wr_latch = wr_pulse && ((wr_target == PGA_TGT_IE) ||
                                 (wr_target == PGA_TGT_PB) ||
                                 (wr_target == PGA_TGT_PC));
  assign wr_index = (wr_target == PGA_TGT_PB) ? `PGA_IDX_PB :
                    (wr_target == PGA_TGT_PC) ? `PGA_IDX_PC :
                                                `PGA_IDX_IE;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_latch
      always_ff @(posedge ref_clk_in)
      begin
        if (!rst_n_in)
          latch_reg[gi] <= `PGA_LATCH_RST;
        else if (ce_in)
        begin
          if (latch_clear)
            latch_reg[gi] <= `PGA_LATCH_RST;
          else if (wr_latch && (wr_index == 2'(gi)))
            latch_reg[gi] <= data_s;
        end
      end
    end
  endgenerate

  // Disk reset latch: set by either reset, released only by a host write.
  // An external reset that overlaps the write wins, so the drive is never
  // let out of reset while the reset pin is still active.
  logic disk_rst_reg;
  wire logic drst_write = wr_pulse && (wr_target == PGA_TGT_DRST);

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      disk_rst_reg <= `PGA_DRST_RST;
    else if (ce_in)
    begin
      if (latch_clear)
        disk_rst_reg <= `PGA_DRST_RST;
      else if (drst_write)
        disk_rst_reg <= 1'b0;
    end
  end

  // Read-back selector.
  logic [7:0] rd_mux;
  assign rd_mux = (rd_target == PGA_TGT_IE) ? latch_reg[`PGA_IDX_IE] :
                  (rd_target == PGA_TGT_PB) ? latch_reg[`PGA_IDX_PB] :
                  (rd_target == PGA_TGT_PC) ? latch_reg[`PGA_IDX_PC] :
                  (rd_target == PGA_TGT_PA) ? pa_s :
                                              8'h00;

  wire logic rd_valid = io_cycle && rd_act && (rd_target != PGA_TGT_NONE);

  // Reads only load the output register; no stored state is touched.
  logic [7:0] rd_data_reg;
  logic       rd_oe_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_reg <= 8'h00;
      rd_oe_reg   <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_data_reg <= rd_valid ? rd_mux : 8'h00;
      rd_oe_reg   <= rd_valid;
    end
  end

  assign host_data_out    = rd_data_reg;
  assign host_data_oe_out = rd_oe_reg;

  // Interrupt request: enabled input lines ORed together.
  logic [6:0] irq_terms;
  logic       irq_reg;
  assign irq_terms = pa_s[`PGA_EN_MSB:`PGA_EN_LSB] &
                     latch_reg[`PGA_IDX_IE][`PGA_EN_MSB:`PGA_EN_LSB];

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      irq_reg <= 1'b0;
    else if (ce_in)
      irq_reg <= |irq_terms;
  end

  assign host_irq_out = irq_reg;

  // Selects are registered so the pins never glitch during decode.
  logic rom_sel_n_reg;
  logic disk_sel_n_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rom_sel_n_reg  <= 1'b1;
      disk_sel_n_reg <= 1'b1;
    end
    else if (ce_in)
    begin
      rom_sel_n_reg  <= !rom_sel;
      disk_sel_n_reg <= !disk_sel;
    end
  end

  assign rom_select_n_out  = rom_sel_n_reg;
  assign disk_select_n_out = disk_sel_n_reg;
  assign disk_reset_n_out  = !disk_rst_reg;

  // A one in a latch bit pulls the matching pin low.
  assign port_b_pins_n_out = ~latch_reg[`PGA_IDX_PB];
  assign port_c_pins_n_out = ~latch_reg[`PGA_IDX_PC];

endmodule : pga_io_gate

// ---- verification/pga_io_gate_monitor.sv ----
`timescale 1ns/1ps
module pga_io_gate_monitor (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] host_addr_in,
  input wire logic [7:0]  host_data_in,
  input wire logic        host_data_oe_out,
  input wire logic        host_iorq_n_in,
  input wire logic        host_mreq_n_in,
  input wire logic        host_m1_n_in,
  input wire logic        host_rd_n_in,
  input wire logic        host_wr_n_in,
  input wire logic [7:0]  interrupt_input_port_in,
  input wire logic        host_irq_out,
  input wire logic        external_reset_in,
  input wire logic [7:0]  port_b_pins_n_out,
  input wire logic [7:0]  port_c_pins_n_out,
  input wire logic        rom_select_n_out,
  input wire logic        disk_select_n_out,
  input wire logic        disk_reset_n_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Latches may only move within four cycles of a write or reset pin.
  logic [2:0] quiet_reg;
  wire        io_cyc = !host_iorq_n_in && host_m1_n_in;
  always_ff @(posedge ref_clk_in)
    if (!rst_n_in || !host_wr_n_in || external_reset_in)
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h4)
      quiet_reg <= quiet_reg + 3'h1;
  sequence wr_seq(a);
    $fell(host_wr_n_in) && io_cyc && host_addr_in[7:0] == a
      && !external_reset_in;
  endsequence
  AST_PB_LOAD: assert property (
    wr_seq(8'h81) |-> ##3 port_b_pins_n_out == ~$past(host_data_in, 3))
    else $error("port B pins do not show inverted write data");
  AST_PC_LOAD: assert property (
    wr_seq(8'h82) |-> ##3 port_c_pins_n_out == ~$past(host_data_in, 3))
    else $error("port C pins do not show inverted write data");
  AST_STILL: assert property (
    quiet_reg == 3'h4 |-> $stable(port_b_pins_n_out)
      && $stable(port_c_pins_n_out) && $stable(disk_reset_n_out))
    else $error("stored state moved without a write");
  AST_OE_CAUSE: assert property (
    host_data_oe_out |-> !$past(host_rd_n_in, 3) || !$past(host_rd_n_in, 4))
    else $error("bus driven without a read strobe");
  AST_IRQ_OFF: assert property (
    (interrupt_input_port_in[6:0] == 7'h00) [*4] |-> !host_irq_out)
    else $error("interrupt raised with all sources low");
  AST_ROM_SEL: assert property (
    rom_select_n_out == !$past(!host_mreq_n_in && host_addr_in[15]
      && (!host_rd_n_in || !host_wr_n_in), 3))
    else $error("program ROM select wrong");
  AST_DISK_SEL: assert property (
    disk_select_n_out == !$past(io_cyc && host_addr_in[7:4] == 4'h6, 3))
    else $error("disk select wrong");
  AST_DRST_CLR: assert property (
    wr_seq(8'h83) |-> ##3 disk_reset_n_out)
    else $error("disk reset not cleared by write");
  AST_EXT_RST: assert property (
    $rose(external_reset_in) |-> ##3 !disk_reset_n_out
      && port_b_pins_n_out == 8'hff && port_c_pins_n_out == 8'hff)
    else $error("reset pin did not clear latches");
endmodule : pga_io_gate_monitor

bind pga_io_gate pga_io_gate_monitor u_mon (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .host_addr_in(host_addr_in), .host_data_in(host_data_in),
  .host_data_oe_out(host_data_oe_out), .host_iorq_n_in(host_iorq_n_in),
  .host_mreq_n_in(host_mreq_n_in), .host_m1_n_in(host_m1_n_in),
  .host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in),
  .interrupt_input_port_in(interrupt_input_port_in),
  .host_irq_out(host_irq_out), .external_reset_in(external_reset_in),
  .port_b_pins_n_out(port_b_pins_n_out),
  .port_c_pins_n_out(port_c_pins_n_out),
  .rom_select_n_out(rom_select_n_out),
  .disk_select_n_out(disk_select_n_out),
  .disk_reset_n_out(disk_reset_n_out));

// ---- verification/pga_host_model.sv ----
`timescale 1ns/1ps
module pga_host_model (
  input  wire logic  ref_clk_in,
  output logic [15:0] addr_out,
  output logic [7:0]  data_out,
  output logic        iorq_n_out,
  output logic        mreq_n_out,
  output logic        rd_n_out,
  output logic        wr_n_out
);
  initial
  begin
    addr_out = 16'h0000;
    data_out = 8'h5a;
    {iorq_n_out, mreq_n_out, rd_n_out, wr_n_out} = 4'hf;
  end
  task automatic cycle(input logic mem, input logic wr,
                       input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out   = a;
    data_out   = d;
    iorq_n_out = mem;
    mreq_n_out = !mem;
    rd_n_out   = wr;
    wr_n_out   = !wr;
    // Strobe held long enough for the two-stage input sampling.
    repeat (5) @(negedge ref_clk_in);
    {iorq_n_out, mreq_n_out, rd_n_out, wr_n_out} = 4'hf;
    data_out = ~d;
    repeat (4) @(negedge ref_clk_in);
  endtask : cycle
endmodule : pga_host_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        ext_rst = 1'b0;
  logic        m1_n = 1'b1;
  logic [7:0]  pa = 8'h00;
  logic [31:0] lfsr = 32'h000168f8;
  logic [7:0]  exp_q[$];
  logic [7:0]  v, w;
  logic        oe_d = 1'b0;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  wire [15:0]  addr;
  wire [7:0]   hdrv, dout, bus, pb_n, pc_n;
  wire         oe, iorq_n, mreq_n, rd_n, wr_n, irq, rom_n, disk_n, drst_n;
  logic [15:0] sel_a[4] = '{16'h8000, 16'h7fff, 16'h0065, 16'h0070};
  logic [7:0]  sel_e[4] = '{8'h01, 8'h03, 8'h02, 8'h03};
  always #12.5 ref_clk_in = ~ref_clk_in;
  assign bus = (oe === 1'b1) ? dout : hdrv;
  pga_host_model host (.ref_clk_in(ref_clk_in), .addr_out(addr),
    .data_out(hdrv), .iorq_n_out(iorq_n), .mreq_n_out(mreq_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n));
  pga_io_gate u_pga_io_gate (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .host_addr_in(addr), .host_data_in(bus),
    .host_data_out(dout), .host_data_oe_out(oe), .host_iorq_n_in(iorq_n),
    .host_mreq_n_in(mreq_n), .host_m1_n_in(m1_n), .host_rd_n_in(rd_n),
    .host_wr_n_in(wr_n), .host_irq_out(irq),
    .interrupt_input_port_in(pa), .external_reset_in(ext_rst),
    .port_b_pins_n_out(pb_n), .port_c_pins_n_out(pc_n),
    .rom_select_n_out(rom_n), .disk_select_n_out(disk_n),
    .disk_reset_n_out(drst_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    host.cycle(1'b0, 1'b1, {8'h00, a}, d);
  endtask : io_wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.cycle(1'b0, 1'b0, {8'h00, a}, 8'h00);
  endtask : rd
  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Every rise of the bus drive must match the oldest expected read.
  always @(negedge ref_clk_in)
  begin
    if (oe && !oe_d)
      check(dout, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    oe_d = oe;
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    check(pb_n, 8'hff);
    check({7'h00, drst_n}, 8'h00);
    for (int i = 0; i < 3; i++)
      rd(8'h80 + 8'(i), 8'h00);
    v = rnd();
    w = rnd();
    io_wr(8'h81, v);
    io_wr(8'h82, w);
    check(pb_n, ~v);
    check(pc_n, ~w);
    io_wr(8'h84, 8'h00);
    rd(8'h81, v);
    rd(8'h82, w);
    host.cycle(1'b0, 1'b0, 16'h0084, 8'h00);
    check(pb_n, ~v);
    check({7'h00, drst_n}, 8'h00);
    io_wr(8'h83, rnd());
    check({7'h00, drst_n}, 8'h01);
    check(pc_n, ~w);
    io_wr(8'h80, 8'h05);
    rd(8'h80, 8'h05);
    pa = 8'h02;
    repeat (5) @(negedge ref_clk_in);
    check({7'h00, irq}, 8'h00);
    pa = 8'h04;
    repeat (5) @(negedge ref_clk_in);
    check({7'h00, irq}, 8'h01);
    io_wr(8'h80, 8'h00);
    check({7'h00, irq}, 8'h00);
    io_wr(8'h80, 8'hff);
    pa = 8'h80;
    rd(8'h83, 8'h80);
    check({7'h00, irq}, 8'h00);
    pa = 8'h00;
    for (int i = 0; i < 4; i++)
      fork
        host.cycle(1'(i < 2), 1'b0, sel_a[i], 8'h00);
        begin
          repeat (5) @(negedge ref_clk_in);
          check({6'h00, rom_n, disk_n}, sel_e[i]);
        end
      join
    // Interrupt acknowledge: an I/O read with M1 low must not drive the bus.
    m1_n = 1'b0;
    fork
      host.cycle(1'b0, 1'b0, 16'h0080, 8'h00);
      begin
        repeat (5) @(negedge ref_clk_in);
        check({7'h00, oe}, 8'h00);
      end
    join
    m1_n = 1'b1;
    ext_rst = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    ext_rst = 1'b0;
    rd(8'h80, 8'h00);
    check(pb_n, 8'hff);
    check(pc_n, 8'hff);
    check({7'h00, drst_n}, 8'h00);
    check(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule : tb
